// ===== common/edz_cfg.svh
`ifndef EDZ_CFG_SVH
`define EDZ_CFG_SVH
// Overview of operation
// - direction input low counts up clockwise, high counts down clockwise
// - a configuration option inverts the polarity of the direction input
// - a direction input change after start-up is an error, not a setting
// - on that error the lamp turns on and the status output goes low
// - no valid position for about 150 ms after power-on; master waits
// - an asserted set input makes the current position the new zero
// - the set input is recognised after about 1 ms of processing
// - after zeroing, 15 ms busy with no valid data and status held low
// - without a fault or zeroing the lamp is off and the status output is high
// - in serial-only mode a latched fault clears only at power removal

// clock and timing
`define EDZ_CLK_NS 8
`define EDZ_PWRON_MS 150
`define EDZ_SET_MS 1
`define EDZ_ZERO_MS 15
`define EDZ_MS_CYC(ms) (((ms) * 1000000 + `EDZ_CLK_NS - 1) / `EDZ_CLK_NS)

// widths
`define EDZ_POS_W 17
`define EDZ_EV_W 4

// register offsets (word index)
`define EDZ_REG_CTRL 4'h0
`define EDZ_REG_STATUS 4'h1
`define EDZ_REG_MASK 4'h2
`define EDZ_REG_POS 4'h3

// control register bits
`define EDZ_CTRL_INV 0
`define EDZ_CTRL_BISS 1
`define EDZ_CTRL_FCLR 2

// event bits of status and mask
`define EDZ_EV_DIRERR 0
`define EDZ_EV_ZERO 1
`define EDZ_EV_READY 2
`define EDZ_EV_FRAME 3

// position register bits
`define EDZ_POS_VALID 31
`define EDZ_POS_FAULT 30
`define EDZ_POS_BUSY 29
`endif

// ===== common/edz_pkg.sv
`include "edz_cfg.svh"
package edz_pkg;
    typedef enum logic {EDZ_PWRON, EDZ_RUN} edz_mode_e;
    typedef logic [`EDZ_POS_W-1:0] edz_pos_t;
    typedef logic [`EDZ_EV_W-1:0] edz_ev_t;
endpackage

// ===== common/edz_tmr_if.sv
// start, abort and expiry of one interval timer
interface edz_tmr_if;
    logic start;
    logic stop;
    logic [31:0] len;
    logic busy;
    logic done;
    modport ctl(output start, output stop, output len,
                input busy, input done);
    modport tmr(input start, input stop, input len,
                output busy, output done);
endinterface

// ===== logic/edz_ctrl.sv
`include "edz_cfg.svh"
module edz_ctrl
    import edz_pkg::*;
#(
    parameter int unsigned PWRON_CYC = `EDZ_MS_CYC(`EDZ_PWRON_MS),
    parameter int unsigned SET_CYC = `EDZ_MS_CYC(`EDZ_SET_MS),
    parameter int unsigned ZERO_CYC = `EDZ_MS_CYC(`EDZ_ZERO_MS)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // pins from outside
    input wire logic dir_pin,
    input wire logic set_pin,
    input wire logic link_clk,
    // sensor position
    input wire logic [`EDZ_POS_W-1:0] raw_pos,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // conditioned position
    output logic [`EDZ_POS_W-1:0] pos_out,
    output logic pos_valid,
    output logic [`EDZ_POS_W-1:0] frame_pos,
    // status pin, lamp and interrupt
    output logic stat_o,
    output logic stat_oe,
    output logic led_on,
    output logic irq
);
    typedef struct packed {
        logic dir_m;
        logic dir_s;
        logic set_m;
        logic set_s;
        logic lck_m;
        logic lck_s;
        logic lck_d;
        edz_mode_e mode;
        logic pwr_go;
        logic dir_ref;
        edz_pos_t offset;
        logic inv;
        logic biss;
        logic fault;
        logic set_arm;
        edz_ev_t ev;
        edz_ev_t mask;
        logic [31:0] rdata;
        edz_pos_t pos_out;
        logic pos_valid;
        edz_pos_t frame_pos;
        logic stat_o;
        logic stat_oe;
        logic led_on;
        logic irq;
    } edz_st_s;

    edz_st_s s;
    edz_st_s next_s;
    logic rev;
    logic zero_go;
    edz_ev_t ev_set;
    edz_ev_t ev_clr;

    edz_tmr_if pw ();
    edz_tmr_if st ();
    edz_tmr_if zt ();

    // reported value from raw position, zero point and sense
    function automatic edz_pos_t edz_calc(edz_pos_t raw, edz_pos_t off,
                                          logic down);
        edz_pos_t r;
        r = down ? edz_pos_t'(off - raw) : edz_pos_t'(raw - off);
        return r;
    endfunction

    edz_timer u_pwr (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .t(pw.tmr)
    );
    edz_timer u_set (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .t(st.tmr)
    );
    edz_timer u_zero (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .t(zt.tmr)
    );

    assign rev = s.dir_ref ^ s.inv;

    assign pw.start = (s.mode == EDZ_PWRON) && !s.pwr_go;
    assign pw.stop = 1'b0;
    assign pw.len = PWRON_CYC;

    // set must stay high for the recognition delay
    assign st.start = (s.mode == EDZ_RUN) && s.set_s && s.set_arm &&
                      !st.busy && !zt.busy;
    assign st.stop = !s.set_s;
    assign st.len = SET_CYC;

    assign zero_go = st.done && s.set_s;
    assign zt.start = zero_go;
    assign zt.stop = 1'b0;
    assign zt.len = ZERO_CYC;

    // events and write-one-to-clear
    always_comb begin
        ev_set = '0;
        ev_set[`EDZ_EV_DIRERR] = (s.mode == EDZ_RUN) && (s.dir_s != s.dir_ref);
        ev_set[`EDZ_EV_ZERO] = zt.done;
        ev_set[`EDZ_EV_READY] = pw.done;
        ev_set[`EDZ_EV_FRAME] = s.lck_d && !s.lck_s;
        ev_clr = '0;
        if (reg_wr && reg_addr == `EDZ_REG_STATUS) begin
            ev_clr = reg_wdata[`EDZ_EV_W-1:0];
        end
    end

    // next state of the whole block
    always_comb begin
        next_s = s;
        next_s.dir_m = dir_pin;
        next_s.dir_s = s.dir_m;
        next_s.set_m = set_pin;
        next_s.set_s = s.set_m;
        next_s.lck_m = link_clk;
        next_s.lck_s = s.lck_m;
        next_s.lck_d = s.lck_s;
        if (s.mode == EDZ_PWRON) begin
            next_s.pwr_go = 1'b1;
            if (pw.done) begin
                next_s.mode = EDZ_RUN;
                next_s.dir_ref = s.dir_s;
            end
        end
        // control writes; a fault clear is honoured in the other mode only
        if (reg_wr && reg_addr == `EDZ_REG_CTRL) begin
            next_s.inv = reg_wdata[`EDZ_CTRL_INV];
            next_s.biss = reg_wdata[`EDZ_CTRL_BISS];
            // no clear while in serial-only mode
            if (s.biss && reg_wdata[`EDZ_CTRL_FCLR]) begin
                next_s.fault = 1'b0;
            end
        end
        // late direction change latches a fault
        if (ev_set[`EDZ_EV_DIRERR]) begin
            next_s.fault = 1'b1;
        end
        if (reg_wr && reg_addr == `EDZ_REG_MASK) begin
            next_s.mask = reg_wdata[`EDZ_EV_W-1:0];
        end
        // set wins over clear
        next_s.ev = (s.ev & ~ev_clr) | ev_set;
        // current position becomes the zero point
        if (zero_go) begin
            next_s.offset = raw_pos;
            next_s.set_arm = 1'b0;
        end
        if (!s.set_s) begin
            next_s.set_arm = 1'b1;
        end
        // snapshot on every falling edge of the link clock
        if (ev_set[`EDZ_EV_FRAME]) begin
            next_s.frame_pos = s.pos_out;
        end
        // read data only in the cycle after the strobe
        next_s.rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                `EDZ_REG_CTRL: begin
                    next_s.rdata[`EDZ_CTRL_INV] = s.inv;
                    next_s.rdata[`EDZ_CTRL_BISS] = s.biss;
                end
                `EDZ_REG_STATUS: next_s.rdata[`EDZ_EV_W-1:0] = s.ev;
                `EDZ_REG_MASK: next_s.rdata[`EDZ_EV_W-1:0] = s.mask;
                `EDZ_REG_POS: begin
                    next_s.rdata[`EDZ_POS_W-1:0] = s.pos_out;
                    next_s.rdata[`EDZ_POS_VALID] = s.pos_valid;
                    next_s.rdata[`EDZ_POS_FAULT] = s.fault;
                    next_s.rdata[`EDZ_POS_BUSY] = zt.busy;
                end
                default: next_s.rdata = 32'h0;
            endcase
        end
        next_s.pos_out = edz_calc(raw_pos, s.offset, rev);
        // data invalid while settling or zeroing
        next_s.pos_valid = (s.mode == EDZ_RUN) && !zt.busy && !zero_go;
        next_s.stat_o = 1'b0;
        next_s.stat_oe = s.fault | zt.busy;
        next_s.led_on = s.fault;
        next_s.irq = |(s.ev & s.mask);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign pos_out = s.pos_out;
    assign pos_valid = s.pos_valid;
    assign frame_pos = s.frame_pos;
    assign stat_o = s.stat_o;
    assign stat_oe = s.stat_oe;
    assign led_on = s.led_on;
    assign irq = s.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // up count follows raw position when not reversed
    AST_DIR_FWD: assert property (
        s.mode == EDZ_RUN && !rev && $stable(rev) && $stable(s.offset) &&
        raw_pos == edz_pos_t'($past(raw_pos) + 1'b1)
        |=> pos_out == edz_pos_t'($past(pos_out) + 1'b1))
        else $error("forward sense not counting up");
    AST_DIR_REV: assert property (
        s.mode == EDZ_RUN && rev && $stable(rev) && $stable(s.offset) &&
        raw_pos == edz_pos_t'($past(raw_pos) + 1'b1)
        |=> pos_out == edz_pos_t'($past(pos_out) - 1'b1))
        else $error("reverse sense not counting down");
    // toggling the inversion negates the value
    AST_INV: assert property (
        s.mode == EDZ_RUN && $changed(s.inv) && $stable(raw_pos) &&
        $stable(s.offset) && $stable(s.dir_ref)
        |=> pos_out == edz_pos_t'(0 - $past(pos_out)))
        else $error("inversion did not reverse sense");
    AST_DIR_ERR: assert property (
        s.mode == EDZ_RUN && s.dir_s != s.dir_ref |=> s.fault)
        else $error("direction change not flagged");
    // fault turns the lamp on and drives status low
    AST_FAULT_PINS: assert property (
        s.fault |=> led_on && stat_oe)
        else $error("fault not shown on pins");
    // no valid data before start-up ends
    AST_PWRON: assert property (
        s.mode == EDZ_PWRON |=> !pos_valid)
        else $error("valid data during power-on");
    // zero point takes the raw position
    AST_ZERO: assert property (
        zero_go |=> s.offset == $past(raw_pos))
        else $error("zero point not taken");
    // set dropped before the delay ends stops the timer
    AST_SET_SHORT: assert property (
        st.busy && !s.set_s |=> !st.busy && !st.done)
        else $error("short set pulse accepted");
    // busy period hides data and pulls status low
    AST_BUSY: assert property (
        zt.busy |=> stat_oe && !pos_valid)
        else $error("zeroing period not signalled");
    AST_IDLE: assert property (
        !s.fault && !zt.busy |=> !stat_oe && !led_on)
        else $error("fault shown without cause");
    AST_LATCH: assert property (
        s.fault && !s.biss |=> s.fault)
        else $error("fault cleared in serial mode");
    // reference direction never moves once running
    AST_SAMPLE: assert property (
        s.mode == EDZ_RUN && $past(s.mode) == EDZ_RUN |-> $stable(s.dir_ref))
        else $error("direction reference changed");
endmodule

// ===== logic/edz_timer.sv
module edz_timer
    import edz_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control
    edz_tmr_if.tmr t
);
    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
        logic done;
    } edz_tmr_s;

    edz_tmr_s s;
    edz_tmr_s next_s;

    // count down, one-cycle done at expiry
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (t.stop) begin
            next_s.busy = 1'b0;
            next_s.cnt = 32'h0;
        end else if (t.start) begin
            next_s.busy = 1'b1;
            next_s.cnt = t.len;
        end else if (s.busy) begin
            if (s.cnt <= 32'h1) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end else begin
                next_s.cnt = s.cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign t.busy = s.busy;
    assign t.done = s.done;
endmodule

// ===== verification/edz_link_master.sv
`include "edz_cfg.svh"
module edz_link_master (
    // link clock to the device
    output logic link_clk,
    // frame handshake with the bench
    input wire logic frame_req,
    output logic frame_done,
    // position snapshot seen by the master
    input wire logic [`EDZ_POS_W-1:0] frame_pos,
    output logic [`EDZ_POS_W-1:0] cap_pos
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NBITS = 18;

    // frames on request
    // the bench asks for a frame only once the device reports valid data;
    // the clock rests high between frames and runs at 160 ns per bit
    initial begin
        link_clk = 1'b1;
        frame_done = 1'b0;
        cap_pos = '0;
        forever begin
            wait (frame_req === 1'b1);
            #35; // phase unrelated to the core clock
            repeat (NBITS) begin
                link_clk = 1'b0;
                #80;
                link_clk = 1'b1;
                #80;
            end
            cap_pos = frame_pos;
            frame_done = 1'b1;
            wait (frame_req === 1'b0);
            frame_done = 1'b0;
        end
    end
endmodule

// ===== verification/tb_top.sv
module tb_top
    import edz_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 50;
    localparam int SC = 10;
    localparam int ZC = 30;
    logic core_clk;
    logic sys_rst = 1'b1;
    logic dir_pin = 1'b0;
    logic set_pin = 1'b0;
    logic frame_req = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    edz_pos_t raw_pos = '0;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    logic [31:0] exp_w;
    edz_pos_t pos_out, frame_pos, cap_pos;
    logic pos_valid, stat_o, stat_oe, led_on, irq, link_clk, frame_done;
    logic stat_line;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int t;

    // open collector status line with its pull-up
    assign stat_line = stat_oe ? stat_o : 1'b1;

    edz_ctrl #(.PWRON_CYC(PW), .SET_CYC(SC), .ZERO_CYC(ZC)) edz_ctrl_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .dir_pin(dir_pin),
        .set_pin(set_pin), .link_clk(link_clk), .raw_pos(raw_pos),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_out(pos_out),
        .pos_valid(pos_valid), .frame_pos(frame_pos), .stat_o(stat_o),
        .stat_oe(stat_oe), .led_on(led_on), .irq(irq));

    edz_link_master edz_link_master_i (
        .link_clk(link_clk), .frame_req(frame_req),
        .frame_done(frame_done), .frame_pos(frame_pos), .cap_pos(cap_pos));

    // core clock, 8 ns
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic complete_run;
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            complete_run;
        end
    end

    task automatic chk_bit(logic got, logic exp, string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_word(logic [31:0] got, logic [31:0] exp, string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the read edge
    task automatic rd_reg(logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    // power cycle with a given direction level and invert option
    task automatic por(logic d, logic inv);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        dir_pin <= d;
        raw_pos <= 17'h00064;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        tick(1);
        chk_bit(pos_valid, 1'b0, "valid right after reset");
        chk_bit(stat_line, 1'b1, "status low after reset");
        chk_bit(led_on, 1'b0, "lamp on after reset");
        wr(4'h0, {31'h0, inv});
        tick(PW - 8);
        chk_bit(pos_valid, 1'b0, "valid too early");
        tick(16);
        chk_bit(pos_valid, 1'b1, "never valid");
        rd_reg(4'h1);
        chk_bit(rd[2], 1'b1, "ready event missing");
        exp_w = (d ^ inv) ? 32'h8001FF9C : 32'h80000064;
        rd_reg(4'h3);
        chk_word(rd, exp_w, "position word");
    endtask

    initial begin
        // every direction level against every invert setting
        for (int i = 0; i < 4; i++) begin
            por(i[1], i[0]);
            exp_w = (i[1] ^ i[0]) ? 32'h0001FF9C : 32'h00000064;
            chk_word({15'h0, pos_out}, exp_w, "sense");
            // two single steps clockwise
            repeat (2) begin
                @(posedge core_clk);
                raw_pos <= raw_pos + 17'h00001;
            end
            tick(2);
            exp_w = (i[1] ^ i[0]) ? 32'h0001FF9A : 32'h00000066;
            chk_word({15'h0, pos_out}, exp_w, "step");
            @(posedge core_clk);
            raw_pos <= 17'h00064;
        end
        // short set pulse is ignored
        @(posedge core_clk);
        set_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        set_pin <= 1'b0;
        tick(SC + 8);
        chk_bit(stat_line, 1'b1, "short set taken");
        chk_word({15'h0, pos_out}, 32'h00000064, "short set");
        // zeroing, set held high
        @(posedge core_clk);
        set_pin <= 1'b1;
        tick(5);
        chk_bit(stat_line, 1'b1, "set taken too early");
        t = 5;
        while (stat_line !== 1'b0 && t < SC + 20) begin
            tick(1);
            t++;
        end
        chk_bit(t >= SC && t <= SC + 8, 1'b1, "set delay");
        @(posedge core_clk);
        set_pin <= 1'b0;
        raw_pos <= 17'h00096;
        rd_reg(4'h3);
        chk_bit(pos_valid, 1'b0, "valid while zeroing");
        chk_word(rd, 32'h20000032, "busy word");
        t = 0;
        while (stat_line !== 1'b1 && t < ZC + 20) begin
            tick(1);
            t++;
        end
        chk_bit(t >= ZC - 4 && t <= ZC + 2, 1'b1, "zeroing time");
        tick(4);
        chk_bit(pos_valid, 1'b1, "valid after zeroing");
        chk_word({15'h0, pos_out}, 32'h00000032, "new zero");
        rd_reg(4'h1);
        chk_bit(rd[1], 1'b1, "zeroing event missing");
        rd_reg(4'h3);
        chk_word(rd, 32'h80000032, "position word");
        // interrupt raised, cleared, mask and unmapped reads
        wr(4'h2, 32'h00000002);
        tick(2);
        chk_bit(irq, 1'b1, "irq not raised");
        wr(4'h1, 32'h00000002);
        tick(2);
        chk_bit(irq, 1'b0, "irq not cleared");
        rd_reg(4'h2);
        chk_word(rd, 32'h00000002, "mask readback");
        rd_reg(4'h0);
        chk_word(rd, 32'h00000001, "control readback");
        rd_reg(4'hF);
        chk_word(rd, 32'h00000000, "unmapped read");
        // one link frame, requested only while data are valid
        @(posedge core_clk);
        frame_req <= 1'b1;
        t = 0;
        while (frame_done !== 1'b1 && t < 600) begin
            tick(1);
            t++;
        end
        @(posedge core_clk);
        frame_req <= 1'b0;
        chk_word({15'h0, cap_pos}, 32'h00000032, "frame value");
        rd_reg(4'h1);
        chk_bit(rd[3], 1'b1, "frame event missing");
        // direction change in run
        @(posedge core_clk);
        dir_pin <= 1'b0;
        tick(8);
        chk_bit(led_on, 1'b1, "lamp off on fault");
        chk_bit(stat_line, 1'b0, "status high on fault");
        rd_reg(4'h1);
        chk_bit(rd[0], 1'b1, "fault event missing");
        chk_word({15'h0, pos_out}, 32'h00000032, "sense kept");
        rd_reg(4'h3);
        chk_word(rd, 32'hC0000032, "fault word");
        // clear attempt in serial-only mode, inversion dropped too
        wr(4'h0, 32'h00000004);
        tick(3);
        chk_bit(led_on, 1'b1, "fault cleared by write");
        chk_bit(stat_line, 1'b0, "status released");
        chk_word({15'h0, pos_out}, 32'h0001FFCE, "inversion");
        // other mode clears once the direction is back
        @(posedge core_clk);
        dir_pin <= 1'b1;
        wr(4'h0, 32'h00000003);
        wr(4'h0, 32'h00000007);
        tick(3);
        chk_bit(led_on, 1'b0, "fault kept in other mode");
        chk_bit(stat_line, 1'b1, "status held low");
        complete_run;
    end
endmodule
